// *** lbc_pkg.sv ***
`default_nettype none
package lbc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  // flash bus timing kept by the host; the read strobe covers access times up to 100 ns
  localparam int unsigned T_STROBE_NS   = 100;
  localparam int unsigned T_HOLD_NS     = 20;

  function automatic int unsigned ceil_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [3:0] STROBE_CYC = 4'(ceil_cycles(T_STROBE_NS));
  localparam logic [3:0] HOLD_CYC   = 4'(ceil_cycles(T_HOLD_NS));

  // wishbone register byte offsets
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_PINS   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;

  // command register fields
  localparam int unsigned CMD_OP_LSB   = 0;
  localparam int unsigned CMD_CODE_LSB = 8;
  localparam logic [1:0] OP_NONE      = 2'h0;
  localparam logic [1:0] OP_CLEAR     = 2'h1;
  localparam logic [1:0] OP_CONFIG    = 2'h2;
  localparam logic [1:0] OP_CLR_STAT  = 2'h3;

  // pins register fields and reset values
  localparam int unsigned PIN_WP_BIT = 0;
  localparam int unsigned PIN_RP_BIT = 1;
  localparam logic        WP_RESET   = 1'b0;
  localparam logic        RP_RESET   = 1'b1;

  // device status byte bit positions
  localparam int unsigned MACHINE_READY_BIT   = 7;
  localparam int unsigned ERASE_CLEAR_ERR_BIT = 5;
  localparam int unsigned PROG_SET_ERR_BIT    = 4;
  localparam int unsigned SUPPLY_LOW_BIT      = 3;

  // status register fields
  localparam int unsigned ST_BUSY_BIT    = 8;
  localparam int unsigned ST_ERR_BIT     = 9;
  localparam int unsigned ST_REPEAT_BIT  = 10;
  localparam int unsigned ST_REFUSED_BIT = 11;
  localparam int unsigned ST_MODE_LSB    = 12;
  localparam int unsigned ST_PULSE_LSB   = 16;

  // status pin configuration code
  localparam logic [1:0] MODE_LEVEL     = 2'h0;
  localparam logic [7:0] CODE_MODE_MASK = 8'h03;

  typedef enum logic [2:0] {
    CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD
  } lbc_cyc_state_t;

  typedef struct packed {
    logic       start;
    logic       wr;
    logic [7:0] data;
  } lbc_cyc_req_t;

  typedef struct packed {
    logic       done;
    logic [7:0] rdata;
  } lbc_cyc_rsp_t;

  typedef struct packed {
    logic       ce_n;
    logic       we_n;
    logic       oe_n;
    logic [7:0] dq;
    logic       dq_oe_n;
  } lbc_flash_pins_t;
endpackage
`default_nettype wire

// *** lbc_bus_cycle.sv ***
`default_nettype none
module lbc_bus_cycle
  import lbc_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire lbc_cyc_req_t    req_i,
  input  wire logic [7:0]      dq_i,
  output lbc_cyc_rsp_t         rsp_o,
  output lbc_flash_pins_t      pins_o
);
  typedef struct packed {
    lbc_cyc_state_t  st;
    logic [3:0]      cnt;
    logic            wr;
    lbc_cyc_rsp_t    rsp;
    lbc_flash_pins_t pins;
  } lbc_cyc_all_t;

  lbc_cyc_all_t s_r;
  lbc_cyc_all_t s_nxt;

  always_comb begin
    s_nxt          = s_r;
    s_nxt.rsp.done = 1'b0;
    unique case (s_r.st)
      CY_IDLE: begin
        if (req_i.start) begin
          s_nxt.st           = CY_SETUP;
          s_nxt.wr           = req_i.wr;
          s_nxt.pins.ce_n    = 1'b0;
          s_nxt.pins.dq      = req_i.data;
          s_nxt.pins.dq_oe_n = ~req_i.wr;
        end
      end
      CY_SETUP: begin
        s_nxt.st        = CY_STROBE;
        s_nxt.cnt       = STROBE_CYC;
        s_nxt.pins.we_n = ~s_r.wr;
        s_nxt.pins.oe_n = s_r.wr;
      end
      CY_STROBE: begin
        s_nxt.cnt = s_r.cnt - 4'h1;
        if (s_r.cnt == 4'h1) begin
          // data is latched on the rising strobe edge; hold keeps dq valid past it
          s_nxt.st        = CY_HOLD;
          s_nxt.cnt       = HOLD_CYC;
          s_nxt.pins.we_n = 1'b1;
          s_nxt.pins.oe_n = 1'b1;
          if (!s_r.wr) begin
            s_nxt.rsp.rdata = dq_i;
          end
        end
      end
      CY_HOLD: begin
        s_nxt.cnt = s_r.cnt - 4'h1;
        if (s_r.cnt == 4'h1) begin
          s_nxt.st           = CY_IDLE;
          s_nxt.pins.ce_n    = 1'b1;
          s_nxt.pins.dq_oe_n = 1'b1;
          s_nxt.rsp.done     = 1'b1;
        end
      end
      default: s_nxt.st = CY_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r      <= '0;
      s_r.st   <= CY_IDLE;
      s_r.pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq: 8'h00, dq_oe_n: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rsp_o  = s_r.rsp;
  assign pins_o = s_r.pins;
endmodule // lbc_bus_cycle
`default_nettype wire

// *** lbc_host_ctrl.sv ***
`default_nettype none
module lbc_host_ctrl
  import lbc_pkg::*;
#(
  parameter logic [7:0] CLEAR_SETUP_OPC   = 8'h11,
  parameter logic [7:0] CLEAR_CONFIRM_OPC = 8'h22,
  parameter logic [7:0] CONFIG_OPC        = 8'h33,
  parameter logic [7:0] CLEAR_STATUS_OPC  = 8'h44
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [7:0]  dq_i,
  output logic      [7:0]  dq_o,
  output logic             dq_oe_n_o,
  output logic             ce_n_o,
  output logic             we_n_o,
  output logic             oe_n_o,
  output logic             write_protect_o,
  output logic             powerdown_return_pin_n_o,
  input  wire logic        ready_status_pin_i
);
  typedef enum logic [3:0] {
    H_IDLE, H_CLR_SETUP, H_CLR_CONFIRM, H_POLL_WAIT, H_POLL_RD,
    H_CLR_STAT, H_CFG_CMD, H_CFG_CODE, H_CYC_WAIT
  } lbc_host_state_t;

  typedef struct packed {
    lbc_host_state_t st;
    lbc_host_state_t ret;
    logic [1:0]      op;
    logic [7:0]      code;
    logic [7:0]      sr;
    logic            err;
    logic            repeat_pend;
    logic            refused;
    logic [1:0]      mode;
    logic [7:0]      pulses;
    logic            sts_prev;
    logic            wp;
    logic            rp;
    logic            ack;
    logic [31:0]     rdata;
    lbc_cyc_req_t    req;
  } lbc_host_all_t;

  lbc_host_all_t   s_r;
  lbc_host_all_t   s_nxt;
  lbc_cyc_rsp_t    cyc_rsp;
  lbc_flash_pins_t pins;

  function automatic lbc_cyc_req_t wr_req(input logic [7:0] d);
    return '{start: 1'b1, wr: 1'b1, data: d};
  endfunction

  function automatic logic [31:0] status_word(input lbc_host_all_t s);
    logic [31:0] w;
    w                                   = 32'h0000_0000;
    w[7:0]                              = s.sr;
    w[ST_BUSY_BIT]                      = (s.st != H_IDLE);
    w[ST_ERR_BIT]                       = s.err;
    w[ST_REPEAT_BIT]                    = s.repeat_pend;
    w[ST_REFUSED_BIT]                   = s.refused;
    w[ST_MODE_LSB +: 2]                 = s.mode;
    w[ST_PULSE_LSB +: 8]                = s.pulses;
    return w;
  endfunction

  wire logic wb_req   = wb_cyc_i & wb_stb_i & ~s_r.ack;
  wire logic wb_write = wb_req & wb_we_i;
  wire logic clr_run  = (s_r.op == OP_CLEAR) && (s_r.st != H_IDLE);

  always_comb begin
    s_nxt           = s_r;
    s_nxt.ack       = wb_req;
    s_nxt.req.start = 1'b0;
    s_nxt.sts_prev  = ready_status_pin_i;
    // count completion pulses in pulse modes
    if ((s_r.mode != MODE_LEVEL) && s_r.sts_prev && !ready_status_pin_i) begin
      s_nxt.pulses = s_r.pulses + 8'h01;
    end
    if (wb_req) begin
      unique case (wb_adr_i)
        REG_PINS:   s_nxt.rdata = {30'h0, s_r.rp, s_r.wp};
        REG_STATUS: s_nxt.rdata = status_word(s_r);
        default:    s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (wb_write && (wb_adr_i == REG_PINS) && wb_sel_i[0]) begin
      s_nxt.wp = wb_dat_i[PIN_WP_BIT];
      s_nxt.rp = wb_dat_i[PIN_RP_BIT];
    end
    if (!s_nxt.rp) begin
      s_nxt.mode = MODE_LEVEL;
    end
    unique case (s_r.st)
      H_IDLE: begin
        if (wb_write && (wb_adr_i == REG_CMD) && wb_sel_i[0]
            && (wb_dat_i[CMD_OP_LSB +: 2] != OP_NONE)) begin
          s_nxt.op      = wb_dat_i[CMD_OP_LSB +: 2];
          // reserved upper code bits are always sent as zero
          s_nxt.code    = wb_sel_i[1] ? (wb_dat_i[CMD_CODE_LSB +: 8] & CODE_MODE_MASK)
                                      : 8'h00;
          s_nxt.refused = 1'b0;
          unique case (wb_dat_i[CMD_OP_LSB +: 2])
            OP_CLEAR: begin
              if (s_r.wp && s_r.rp) begin
                s_nxt.st  = H_CLR_SETUP;
                s_nxt.err = 1'b0;
              end else begin
                s_nxt.refused = 1'b1;
              end
            end
            OP_CONFIG:   s_nxt.st = H_CFG_CMD;
            default:     s_nxt.st = H_CLR_STAT;
          endcase
        end else if (s_r.repeat_pend && s_r.wp && s_r.rp) begin
          // an aborted clear leaves locks unknown, so it is rerun unasked
          s_nxt.op  = OP_CLEAR;
          s_nxt.st  = H_CLR_SETUP;
          s_nxt.err = 1'b0;
        end
      end
      H_CLR_SETUP: begin
        s_nxt.req = wr_req(CLEAR_SETUP_OPC);
        s_nxt.st  = H_CYC_WAIT;
        s_nxt.ret = H_CLR_CONFIRM;
      end
      H_CLR_CONFIRM: begin
        s_nxt.req = wr_req(CLEAR_CONFIRM_OPC);
        s_nxt.st  = H_CYC_WAIT;
        s_nxt.ret = H_POLL_WAIT;
      end
      H_POLL_WAIT: begin
        // in level mode the pin going high saves polling traffic
        if ((s_r.mode != MODE_LEVEL) || ready_status_pin_i) begin
          s_nxt.req = '{start: 1'b1, wr: 1'b0, data: 8'h00};
          s_nxt.st  = H_CYC_WAIT;
          s_nxt.ret = H_POLL_RD;
        end
      end
      H_POLL_RD: begin
        s_nxt.sr = cyc_rsp.rdata;
        if (!cyc_rsp.rdata[MACHINE_READY_BIT]) begin
          s_nxt.st = H_POLL_WAIT;
        end else if (cyc_rsp.rdata[ERASE_CLEAR_ERR_BIT]) begin
          s_nxt.err = 1'b1;
          s_nxt.st  = H_CLR_STAT;
        end else begin
          s_nxt.repeat_pend = 1'b0;
          s_nxt.st          = H_IDLE;
        end
      end
      H_CLR_STAT: begin
        s_nxt.req = wr_req(CLEAR_STATUS_OPC);
        s_nxt.st  = H_CYC_WAIT;
        s_nxt.ret = H_IDLE;
      end
      H_CFG_CMD: begin
        s_nxt.req = wr_req(CONFIG_OPC);
        s_nxt.st  = H_CYC_WAIT;
        s_nxt.ret = H_CFG_CODE;
      end
      H_CFG_CODE: begin
        s_nxt.req = wr_req(s_r.code);
        s_nxt.st  = H_CYC_WAIT;
        s_nxt.ret = H_IDLE;
        // the device keeps this mode until reconfigured or powered down
        s_nxt.mode   = s_r.code[1:0];
        s_nxt.pulses = 8'h00;
      end
      H_CYC_WAIT: begin
        if (cyc_rsp.done) begin
          s_nxt.st = s_r.ret;
        end
      end
      default: s_nxt.st = H_IDLE;
    endcase
    // dropping powerdown or protect mid-clear aborts it; a cycle in flight
    // still finishes so the flash bus is never left half driven
    if (clr_run && (!s_nxt.rp || !s_nxt.wp) && (s_r.st != H_CYC_WAIT)) begin
      s_nxt.repeat_pend = 1'b1;
      s_nxt.st          = H_IDLE;
      // a cycle not yet launched is dropped, or its done would be taken by the rerun
      s_nxt.req.start   = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r          <= '0;
      s_r.st       <= H_IDLE;
      s_r.ret      <= H_IDLE;
      s_r.mode     <= MODE_LEVEL;
      s_r.wp       <= WP_RESET;
      s_r.rp       <= RP_RESET;
      s_r.sts_prev <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  lbc_bus_cycle lbc_bus_cycle_inst (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .req_i  (s_r.req),
    .dq_i   (dq_i),
    .rsp_o  (cyc_rsp),
    .pins_o (pins)
  );

  assign wb_dat_o                 = s_r.rdata;
  assign wb_ack_o                 = s_r.ack;
  assign dq_o                     = pins.dq;
  assign dq_oe_n_o                = pins.dq_oe_n;
  assign ce_n_o                   = pins.ce_n;
  assign we_n_o                   = pins.we_n;
  assign oe_n_o                   = pins.oe_n;
  assign write_protect_o          = s_r.wp;
  assign powerdown_return_pin_n_o = s_r.rp;
endmodule // lbc_host_ctrl
`default_nettype wire

// *** lbc_host_ctrl_chk.sv ***
`default_nettype none
module lbc_host_ctrl_chk (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic [7:0] dq_o,
  input wire logic       dq_oe_n_o,
  input wire logic       ce_n_o,
  input wire logic       we_n_o,
  input wire logic       oe_n_o,
  input wire logic       write_protect_o,
  input wire logic       powerdown_return_pin_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held past one cycle");
  property p_ack_due; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_due: assert property (p_ack_due)
    else $error("no ack one cycle after request");
  property p_we_width; $fell(we_n_o) |-> !we_n_o [*5] ##1 we_n_o; endproperty
  a_we_width: assert property (p_we_width)
    else $error("write strobe not five cycles");
  property p_oe_width; $fell(oe_n_o) |-> !oe_n_o [*5] ##1 oe_n_o; endproperty
  a_oe_width: assert property (p_oe_width)
    else $error("read strobe not five cycles");
  property p_data_held; !we_n_o |-> !dq_oe_n_o && $stable(dq_o); endproperty
  a_data_held: assert property (p_data_held)
    else $error("write data moved under strobe");
  property p_no_fight; !oe_n_o |-> dq_oe_n_o && !ce_n_o; endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("host drives bus during read");
  property p_hold; $rose(we_n_o) || $rose(oe_n_o) |-> !ce_n_o ##1 ce_n_o && dq_oe_n_o; endproperty
  a_hold: assert property (p_hold)
    else $error("bus cycle hold wrong");
  property p_reset; $fell(rst_i) |-> ce_n_o && !write_protect_o && powerdown_return_pin_n_o; endproperty
  a_reset: assert property (p_reset)
    else $error("pins not at reset levels");
endmodule // lbc_host_ctrl_chk
bind lbc_host_ctrl lbc_host_ctrl_chk lbc_host_ctrl_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .dq_o(dq_o),
  .dq_oe_n_o(dq_oe_n_o), .ce_n_o(ce_n_o), .we_n_o(we_n_o), .oe_n_o(oe_n_o),
  .write_protect_o(write_protect_o), .powerdown_return_pin_n_o(powerdown_return_pin_n_o));
`default_nettype wire

// *** lbc_flash_model.sv ***
`default_nettype none
module lbc_flash_model
  import lbc_pkg::*;
#(
  parameter logic [7:0] SETUP_OPC = 8'h11,
  parameter logic [7:0] CONF_OPC  = 8'h22,
  parameter logic [7:0] CFG_OPC   = 8'h33,
  parameter logic [7:0] CLRS_OPC  = 8'h44,
  parameter int         BUSY_CYC  = 40,
  parameter int         PULSE_CYC = 12
)(
  input  wire logic       clk_i,
  input  wire logic       ce_n_i,
  input  wire logic       we_n_i,
  input  wire logic       oe_n_i,
  input  wire logic [7:0] dq_i,
  input  wire logic       wp_i,
  input  wire logic       pd_n_i,
  input  wire logic       low_i,
  input  wire logic [1:0] ev_i,
  output logic      [7:0] dq_o,
  output logic            pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sr_r = 8'h80;
  logic [7:0] pend_r = 8'h00;
  logic [7:0] last_r = 8'h00;
  logic [3:0] locks_r = 4'ha;
  logic [1:0] mode_r = 2'h0;
  logic       we_d = 1'b1;
  int         busy_r = 0;
  int         pls_r = 0;
  int         clrs_n = 0;
  // program or block erase on one block; chip erase applies the same test per block
  function automatic logic may_alter(input logic lock, input logic wp);
    return !lock || wp;
  endfunction
  // a released bus shows the inverse of the last byte, so a stale read cannot pass
  assign dq_o = (!ce_n_i && !oe_n_i) ? sr_r : ~last_r;
  assign pin_o = (mode_r == 2'h0) ? (busy_r == 0) : (pls_r == 0);
  always @(posedge clk_i) begin
    we_d <= we_n_i;
    if (!ce_n_i && !oe_n_i) last_r <= sr_r;
    if (pls_r > 0) pls_r <= pls_r - 1;
    if ((ev_i & mode_r) != 2'h0) pls_r <= PULSE_CYC;
    if (busy_r > 0) busy_r <= busy_r - 1;
    if (busy_r == 1) begin
      sr_r[7] <= 1'b1;
      locks_r <= 4'h0;
    end
    if (we_n_i && !we_d) begin
      pend_r <= 8'h00;
      if (pend_r == SETUP_OPC) begin
        if (dq_i != CONF_OPC) sr_r[5:4] <= 2'b11;
        else if (!wp_i) sr_r[5] <= 1'b1;
        else if (low_i) sr_r[5:3] <= 3'b101;
        else begin
          sr_r[7] <= 1'b0;
          busy_r <= BUSY_CYC;
        end
      end else if (pend_r == CFG_OPC) begin
        if (dq_i[7:2] != 6'h00) sr_r[5:4] <= 2'b11;
        else mode_r <= dq_i[1:0];
      end else if (dq_i == CLRS_OPC) begin
        sr_r[5:3] <= 3'h0;
        clrs_n <= clrs_n + 1;
      end else pend_r <= dq_i;
    end
    if (!pd_n_i) begin
      mode_r <= 2'h0;
      busy_r <= 0;
      sr_r <= 8'h80;
      if (busy_r > 0) locks_r <= 4'h5;
    end
  end
endmodule // lbc_flash_model
`default_nettype wire

// *** lbc_host_ctrl_bench.sv ***
`default_nettype none
module lbc_host_ctrl_bench
  import lbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic        low = 1'b0;
  logic [1:0]  ev = 2'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic [7:0]  hdq, mdq, bus;
  logic        ack, dq_oe_n, ce_n, we_n, oe_n, wp, pd_n, pin;
  logic [3:0]  locks;
  int          n_fail = 0;
  int          comparisons = 0;
  int          cycles = 0;
  `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
  assign bus = !dq_oe_n ? hdq : mdq;
  assign locks = lbc_flash_model_inst.locks_r;
  lbc_host_ctrl lbc_host_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .dq_i(bus), .dq_o(hdq), .dq_oe_n_o(dq_oe_n),
    .ce_n_o(ce_n), .we_n_o(we_n), .oe_n_o(oe_n), .write_protect_o(wp),
    .powerdown_return_pin_n_o(pd_n), .ready_status_pin_i(pin));
  lbc_flash_model lbc_flash_model_inst (.clk_i(clk_i), .ce_n_i(ce_n), .we_n_i(we_n),
    .oe_n_i(oe_n), .dq_i(bus), .wp_i(wp), .pd_n_i(pd_n), .low_i(low), .ev_i(ev),
    .dq_o(mdq), .pin_o(pin));
  task automatic results();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // busy is polled, never waited out by a fixed count
  task automatic wait_idle();
    repeat (200) begin
      wb(1'b0, REG_STATUS, 32'h0);
      if (q[ST_BUSY_BIT] === 1'b0) return;
    end
  endtask
  task automatic wait_model_busy();
    repeat (100) begin
      @(posedge clk_i);
      if (lbc_flash_model_inst.busy_r > 0) return;
    end
  endtask
  task automatic t_reset_values();
    wb(1'b0, REG_PINS, 32'h0);
    `CHK(q[1:0], 2'b10)
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK(q[13:12], MODE_LEVEL)
    wb(1'b0, 8'h0c, 32'h0);
    `CHK(q, 32'h0)
    `CHK(pin, 1'b1)
    `CHK(lbc_flash_model_inst.may_alter(1'b1, 1'b0), 1'b0)
    `CHK(lbc_flash_model_inst.may_alter(1'b1, 1'b1), 1'b1)
  endtask
  task automatic t_refused();
    wb(1'b1, REG_CMD, 32'h1);
    wait_idle();
    `CHK(q[ST_REFUSED_BIT], 1'b1)
    `CHK(locks, 4'ha)
  endtask
  task automatic t_supply_low();
    wb(1'b1, REG_PINS, 32'h3);
    low <= 1'b1;
    wb(1'b1, REG_CMD, 32'h1);
    wait_idle();
    `CHK(q[ST_ERR_BIT], 1'b1)
    `CHK({q[ERASE_CLEAR_ERR_BIT], q[SUPPLY_LOW_BIT]}, 2'b11)
    `CHK(locks, 4'ha)
    `CHK(lbc_flash_model_inst.sr_r[5:3], 3'h0)
    `CHK(lbc_flash_model_inst.clrs_n, 1)
    wb(1'b1, REG_CMD, 32'h3);
    wait_idle();
    `CHK(lbc_flash_model_inst.clrs_n, 2)
    low <= 1'b0;
  endtask
  task automatic t_clear();
    wb(1'b1, REG_CMD, 32'h1);
    wait_model_busy();
    `CHK(pin, 1'b0)
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK(q[ST_BUSY_BIT], 1'b1)
    wait_idle();
    `CHK(q[7:0], 8'h80)
    `CHK(locks, 4'h0)
    `CHK(pin, 1'b1)
  endtask
  task automatic t_pulse();
    for (int c = 1; c < 4; c++) begin
      wb(1'b1, REG_CMD, {16'h0, 8'(c), 8'h02});
      wait_idle();
      `CHK(q[13:12], 2'(c))
      ev <= 2'h1;
      @(posedge clk_i);
      ev <= 2'h0;
      repeat (2) @(posedge clk_i);
      `CHK(pin, !c[0])
      repeat (20) @(posedge clk_i);
      ev <= 2'h2;
      @(posedge clk_i);
      ev <= 2'h0;
      repeat (20) @(posedge clk_i);
      wb(1'b0, REG_STATUS, 32'h0);
      `CHK(q[23:16], 8'(c % 2 + c / 2))
    end
  endtask
  task automatic t_abort();
    wb(1'b1, REG_CMD, 32'h1);
    wait_model_busy();
    wb(1'b1, REG_PINS, 32'h1);
    // the abort waits for a flash cycle in flight, so poll until the host is idle
    wait_idle();
    `CHK(q[ST_REPEAT_BIT], 1'b1)
    `CHK(q[13:12], MODE_LEVEL)
    wb(1'b1, REG_PINS, 32'h3);
    wait_model_busy();
    wait_idle();
    `CHK(q[ST_REPEAT_BIT], 1'b0)
    `CHK(locks, 4'h0)
  endtask
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset_values();
    t_refused();
    t_supply_low();
    t_clear();
    t_pulse();
    t_abort();
    results();
  end
endmodule // lbc_host_ctrl_bench
`default_nettype wire
